// ---- design/dma_chan_pkg.sv ----
package dma_chan_pkg;

   // ==========================================================
   // trigger codes
   localparam int unsigned EVT_LINES  = 20;
   localparam logic [4:0]  TRIG_NONE  = 5'h00;
   localparam logic [4:0]  TRIG_FIRST = 5'h01;
   localparam logic [4:0]  TRIG_TMR1  = 5'h0d;
   localparam logic [4:0]  TRIG_EXT0  = 5'h0f;
   localparam logic [4:0]  TRIG_LAST  = 5'h14;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFS_CONTROL   = 8'h00;
   localparam logic [7:0] OFS_IRQ_EN    = 8'h04;
   localparam logic [7:0] OFS_STATUS    = 8'h08;
   localparam logic [7:0] OFS_PARAMS    = 8'h0c;
   localparam logic [7:0] OFS_ELEM_NUM  = 8'h10;
   localparam logic [7:0] OFS_FRAME_NUM = 8'h14;

   // ==========================================================
   // field positions
   localparam int unsigned CTL_EN_BIT   = 7;
   localparam int unsigned CTL_FS_BIT   = 5;
   localparam int unsigned CTL_SYNC_MSB = 4;
   localparam int unsigned CTL_SYNC_LSB = 0;
   localparam int unsigned STATUS_W     = 7;
   localparam int unsigned ST_TRIG_BIT  = 6;

   // ==========================================================
   // reset values and write masks
   localparam logic [15:0] CTL_RESET    = 16'h0000;
   localparam logic [15:0] CTL_WMASK    = 16'hfbff;
   localparam logic [15:0] IEN_RESET    = 16'h0003;
   localparam logic [15:0] IEN_WMASK    = 16'h003f;
   localparam logic [6:0]  STS_RESET    = 7'h00;
   localparam logic [15:0] PARAMS_RESET = 16'h0000;
   localparam logic [15:0] COUNT_RESET  = 16'h0001;
   localparam logic [1:0]  BURST_FOUR   = 2'b10;

   // ==========================================================
   // types
   typedef struct packed {
      logic [1:0] destination_burst_select;
      logic       destination_packing_on;
      logic [3:0] destination_port_select;
      logic [1:0] source_burst_select;
      logic       source_packing_on;
      logic [3:0] source_port_select;
      logic [1:0] element_data_type;
   } params_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_MOVE = 2'b10
   } chan_state_type;

endpackage

// ---- design/dma_channel_events.sv ----
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module dma_channel_events (
   // clock and reset
   input  wire logic                         MCLK,
   input  wire logic                         RST,
   // wishbone slave
   input  wire logic                         WB_CYC_I,
   input  wire logic                         WB_STB_I,
   input  wire logic                         WB_WE_I,
   input  wire logic [7:0]                   WB_ADR_I,
   input  wire logic [3:0]                   WB_SEL_I,
   input  wire logic [31:0]                  WB_DAT_I,
   output logic                              WB_ACK_O,
   output logic      [31:0]                  WB_DAT_O,
   // trigger pins, line n-1 carries code n
   input  wire logic [dma_chan_pkg::EVT_LINES-1:0] EVT_PINS,
   // transfer side
   input  wire logic                         ELEM_DONE,
   input  wire logic                         PORT_TIMEOUT,
   output logic                              SRC_REQ,
   output logic                              CHAN_ACTIVE,
   output logic                              DST_BURST4,
   output logic                              SRC_BURST4,
   output dma_chan_pkg::params_type          PORT_PARAMS,
   // interrupt requests
   output logic                              CHAN_IRQ,
   output logic                              BUS_ERR_IRQ
);
   import dma_chan_pkg::*;

   // ==========================================================
   // assertion clock, checks are off while reset is held
   default clocking chk_clock @(posedge MCLK);
   endclocking
   default disable iff (RST);

   // ==========================================================
   // state
   logic [15:0]         ctl_reg;
   logic [15:0]         ctl_next;
   logic [15:0]         ien_reg;
   logic [15:0]         ien_next;
   logic [STATUS_W-1:0] status_reg;
   logic [STATUS_W-1:0] status_next;
   params_type          params_reg;
   params_type          params_next;
   logic [15:0]         elem_num_reg;
   logic [15:0]         elem_num_next;
   logic [15:0]         frame_num_reg;
   logic [15:0]         frame_num_next;
   logic [15:0]         elem_idx_reg;
   logic [15:0]         elem_idx_next;
   logic [15:0]         frame_idx_reg;
   logic [15:0]         frame_idx_next;
   chan_state_type      state_reg;
   chan_state_type      state_next;
   logic                ack_reg;
   logic [31:0]         dat_reg;
   logic                src_req_reg;
   logic                chan_irq_reg;
   logic                berr_irq_reg;
   logic                dst_b4_reg;
   logic                src_b4_reg;
   logic [EVT_LINES-1:0] evt_rise;

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [15:0] data,
                                           input logic [15:0] mask);
      merge16 = (old & ~mask) | (data & mask);
   endfunction

   // ==========================================================
   // bus decode
   wire        bus_req   = WB_CYC_I & WB_STB_I;
   wire        bus_take  = bus_req & ack_reg;
   wire        wr_take   = bus_take & WB_WE_I;
   wire        rd_take   = bus_take & ~WB_WE_I;
   wire        rd_grab   = bus_req & ~ack_reg & ~WB_WE_I;
   wire [5:0]  word_adr  = WB_ADR_I[7:2];
   wire        hit_ctl   = word_adr == OFS_CONTROL[7:2];
   wire        hit_ien   = word_adr == OFS_IRQ_EN[7:2];
   wire        hit_sts   = word_adr == OFS_STATUS[7:2];
   wire        hit_prm   = word_adr == OFS_PARAMS[7:2];
   wire        hit_enum  = word_adr == OFS_ELEM_NUM[7:2];
   wire        hit_fnum  = word_adr == OFS_FRAME_NUM[7:2];
   wire [15:0] wmask     = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
   wire [15:0] wdata     = WB_DAT_I[15:0];
   wire [15:0] prm_bits  = params_reg;
   wire [15:0] sts_bits  = {9'h000, status_reg};
   // unmapped words read as zero and ignore writes
   wire [15:0] rd_mux    = hit_ctl  ? ctl_reg       :
                           hit_ien  ? ien_reg       :
                           hit_sts  ? sts_bits      :
                           hit_prm  ? prm_bits      :
                           hit_enum ? elem_num_reg  :
                           hit_fnum ? frame_num_reg : 16'h0000;

   // ==========================================================
   // trigger selection
   event_catch #(
      .WIDTH (EVT_LINES)
   ) u_evt (
      .clk  (MCLK),
      .rst  (RST),
      .pins (EVT_PINS),
      .rise (evt_rise)
   );

   // code 0 and reserved codes land on constant zero bits
   wire [31:0] evt_map   = {{(31 - EVT_LINES){1'b0}}, evt_rise, 1'b0};
   wire [4:0]  sync_sel  = ctl_reg[CTL_SYNC_MSB:CTL_SYNC_LSB];
   wire        free_run  = sync_sel == TRIG_NONE;
   // every channel decodes the shared pins itself; nothing is consumed
   wire        trig_evt  = evt_map[sync_sel];

   // ==========================================================
   // transfer sequencing
   wire        en         = ctl_reg[CTL_EN_BIT];
   wire        fs         = ctl_reg[CTL_FS_BIT];
   wire        in_wait    = state_reg == ST_WAIT;
   wire        in_move    = state_reg == ST_MOVE;
   wire        start_unit = in_wait & en & (free_run | trig_evt);
   wire        elem_move  = src_req_reg & ELEM_DONE & en;
   wire [15:0] elem_inc   = elem_idx_reg + 16'h0001;
   wire [15:0] frame_inc  = frame_idx_reg + 16'h0001;
   wire [15:0] half_pt    = {1'b0, elem_num_reg[15:1]};
   wire        last_elem  = elem_inc == elem_num_reg;
   wire        last_frame = frame_inc == frame_num_reg;
   // element sync ends the unit after one element, frame sync after a frame
   wire        unit_done  = elem_move & (~fs | last_elem);

   // ==========================================================
   // events
   wire half_evt  = elem_move & (elem_inc == half_pt);
   wire frame_evt = elem_move & last_elem;
   wire block_evt = frame_evt & last_frame;
   wire lastf_evt = start_unit & (elem_idx_reg == 16'h0000)
                    & last_frame;
   // a trigger still lost if it lands on the finishing element
   wire drop_evt  = trig_evt & en & in_move;
   wire trig_resp = start_unit & ~free_run;

   wire [6:0] ev_raw  = {trig_resp, block_evt, lastf_evt, frame_evt,
                         half_evt, drop_evt, PORT_TIMEOUT};
   wire [6:0] set_vec = ev_raw & {1'b1, ien_reg[5:0]};
   // only bits that were captured for the reader are cleared
   wire [6:0] rd_clr  = (rd_take & hit_sts) ? dat_reg[6:0] : 7'h00;
   wire [6:0] svc_clr = {unit_done, 6'h00};

   // ==========================================================
   // register next values
   always_comb begin
      ctl_next = ctl_reg;
      if (wr_take & hit_ctl) begin
         ctl_next = merge16(ctl_reg, wdata, wmask) & CTL_WMASK;
      end
      if (block_evt) begin
         ctl_next[CTL_EN_BIT] = 1'b0;
      end
   end

   assign ien_next = (wr_take & hit_ien)
                   ? merge16(ien_reg, wdata, wmask) & IEN_WMASK
                   : ien_reg;
   assign params_next = (wr_take & hit_prm)
                      ? params_type'(merge16(prm_bits, wdata, wmask))
                      : params_reg;
   assign elem_num_next = (wr_take & hit_enum)
                        ? merge16(elem_num_reg, wdata, wmask)
                        : elem_num_reg;
   assign frame_num_next = (wr_take & hit_fnum)
                         ? merge16(frame_num_reg, wdata, wmask)
                         : frame_num_reg;
   // set beats clear so no event is lost
   assign status_next = (status_reg & ~rd_clr & ~svc_clr) | set_vec;

   always_comb begin
      state_next     = state_reg;
      elem_idx_next  = elem_idx_reg;
      frame_idx_next = frame_idx_reg;
      case (state_reg)
         ST_IDLE: begin
            if (en) begin
               state_next     = ST_WAIT;
               elem_idx_next  = 16'h0000;
               frame_idx_next = 16'h0000;
            end
         end
         ST_WAIT: begin
            if (!en) begin
               state_next = ST_IDLE;
            end else if (start_unit) begin
               state_next = ST_MOVE;
            end
         end
         ST_MOVE: begin
            if (!en) begin
               state_next = ST_IDLE;
            end else if (elem_move) begin
               if (last_elem) begin
                  elem_idx_next  = 16'h0000;
                  frame_idx_next = frame_inc;
               end else begin
                  elem_idx_next = elem_inc;
               end
               if (block_evt) begin
                  state_next = ST_IDLE;
               end else if (unit_done) begin
                  state_next = ST_WAIT;
               end
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // ==========================================================
   // flip-flops
   always_ff @(posedge MCLK) begin
      if (RST) begin
         ctl_reg       <= CTL_RESET;
         ien_reg       <= IEN_RESET;
         status_reg    <= STS_RESET;
         params_reg    <= params_type'(PARAMS_RESET);
         elem_num_reg  <= COUNT_RESET;
         frame_num_reg <= COUNT_RESET;
         elem_idx_reg  <= 16'h0000;
         frame_idx_reg <= 16'h0000;
         state_reg     <= ST_IDLE;
         src_req_reg   <= 1'b0;
         chan_irq_reg  <= 1'b0;
         berr_irq_reg  <= 1'b0;
         dst_b4_reg    <= 1'b0;
         src_b4_reg    <= 1'b0;
      end else begin
         ctl_reg       <= ctl_next;
         ien_reg       <= ien_next;
         status_reg    <= status_next;
         params_reg    <= params_next;
         elem_num_reg  <= elem_num_next;
         frame_num_reg <= frame_num_next;
         elem_idx_reg  <= elem_idx_next;
         frame_idx_reg <= frame_idx_next;
         state_reg     <= state_next;
         src_req_reg   <= state_next == ST_MOVE;
         chan_irq_reg  <= |set_vec[5:1];
         berr_irq_reg  <= set_vec[0];
         // reserved 11b falls back to single access
         dst_b4_reg    <= params_next.destination_burst_select
                          == BURST_FOUR;
         src_b4_reg    <= params_next.source_burst_select == BURST_FOUR;
      end
   end

   // read data is caught one edge before the master takes it
   always_ff @(posedge MCLK) begin
      if (RST) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= bus_req & ~ack_reg;
         dat_reg <= rd_grab ? {16'h0000, rd_mux} : 32'h0000_0000;
      end
   end

   // ==========================================================
   // outputs
   assign WB_ACK_O    = ack_reg;
   assign WB_DAT_O    = dat_reg;
   assign SRC_REQ     = src_req_reg;
   assign CHAN_ACTIVE = ctl_reg[CTL_EN_BIT];
   assign DST_BURST4  = dst_b4_reg;
   assign SRC_BURST4  = src_b4_reg;
   assign PORT_PARAMS = params_reg;
   assign CHAN_IRQ    = chan_irq_reg;
   assign BUS_ERR_IRQ = berr_irq_reg;

   // ==========================================================
   // checks
   chk_frame_waits_trig: assert property (
      (in_wait && en && !free_run && !trig_evt) |=> !in_move)
      else $error("unit started without its trigger");

   chk_elem_single: assert property (
      (elem_move && !fs && !block_evt) |=> (in_wait && !SRC_REQ))
      else $error("element sync moved more than one element");

   chk_free_run_start: assert property (
      (in_wait && en && free_run) |=> SRC_REQ)
      else $error("free running channel did not start");

   chk_reserved_quiet: assert property (
      (sync_sel > TRIG_LAST) |-> !trig_evt)
      else $error("reserved trigger code produced an event");

   chk_chan_irq_cause: assert property (
      CHAN_IRQ |-> $past(|(ev_raw[5:1] & ien_reg[5:1])))
      else $error("channel interrupt without enabled event");

   chk_timeout_berr: assert property (
      (PORT_TIMEOUT && ien_reg[0]) |=> (BUS_ERR_IRQ && status_reg[0]))
      else $error("timeout not reported on bus error line");

   chk_trig_status: assert property (
      trig_resp |=> status_reg[ST_TRIG_BIT])
      else $error("trigger status not set on response");

   chk_drop_gated: assert property (
      (drop_evt && !ien_reg[1] && !status_reg[1]) |=> !status_reg[1])
      else $error("disabled drop event was recorded");

   chk_read_clears: assert property (
      (rd_take && hit_sts && set_vec == 7'h00)
      |=> ((status_reg & $past(dat_reg[6:0])) == 7'h00))
      else $error("status read did not clear its bits");

   chk_block_clears_en: assert property (
      block_evt |=> (!CHAN_ACTIVE && state_reg == ST_IDLE))
      else $error("block done left the channel enabled");

   chk_drop_report: assert property (
      (drop_evt && ien_reg[1]) |=> (status_reg[1] && CHAN_IRQ))
      else $error("enabled drop not reported");

   chk_read_keeps_new: assert property (
      (rd_take && hit_sts && half_evt && ien_reg[2]) |=> status_reg[2])
      else $error("event lost under status read");

   chk_dst_burst: assert property (
      DST_BURST4
      == (PORT_PARAMS.destination_burst_select == BURST_FOUR))
      else $error("destination burst flag disagrees with field");

   chk_block_status: assert property (
      (block_evt && ien_reg[5]) |=> (status_reg[5] && CHAN_IRQ))
      else $error("enabled block event not reported");

   chk_last_status: assert property (
      (lastf_evt && ien_reg[4]) |=> (status_reg[4] && CHAN_IRQ))
      else $error("enabled last frame event not reported");

   chk_frame_status: assert property (
      (frame_evt && ien_reg[3]) |=> (status_reg[3] && CHAN_IRQ))
      else $error("enabled frame event not reported");

   chk_half_status: assert property (
      (half_evt && ien_reg[2]) |=> (status_reg[2] && CHAN_IRQ))
      else $error("enabled half frame event not reported");

   chk_trig_release: assert property (
      unit_done |=> !status_reg[ST_TRIG_BIT])
      else $error("trigger status kept after service");

endmodule

// ---- design/event_catch.sv ----
`timescale 1ns/1ps
module event_catch #(
   parameter int WIDTH = 20
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // raw lines and their rising edges
   input  wire logic [WIDTH-1:0] pins,
   output logic      [WIDTH-1:0] rise
);

   // ==========================================================
   // two-stage synchroniser, then edge detect on clean copy
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] last_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= '0;
         sync_reg <= '0;
         last_reg <= '0;
         rise     <= '0;
      end else begin
         meta_reg <= pins;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
         rise     <= sync_reg & ~last_reg;
      end
   end

endmodule

// ---- verif/dma_channel_events_bench.sv ----
`timescale 1ns/1ps
module dma_channel_events_bench;
   import dma_chan_pkg::*;
   // ==========================================
   // wiring
   logic                 mclk, rst, cyc, stb, we, ack, edone, tmo;
   logic                 req, act, dbur, sbur, irq, berr, tcmd, rprev;
   logic [7:0]           adr;
   logic [3:0]           sel, delay;
   logic [31:0]          wdat, rdat, got;
   logic [15:0]          v;
   logic [EVT_LINES-1:0] pins;
   params_type           prm;
   int                   miscompares, checks, rises, irqs, berrs, dones;
   int                   code;
   int                   mdl[int];

   dma_channel_events dma_channel_events_inst (.MCLK(mclk), .RST(rst),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_ACK_O(ack), .WB_DAT_O(rdat),
      .EVT_PINS(pins), .ELEM_DONE(edone), .PORT_TIMEOUT(tmo),
      .SRC_REQ(req), .CHAN_ACTIVE(act), .DST_BURST4(dbur),
      .SRC_BURST4(sbur), .PORT_PARAMS(prm), .CHAN_IRQ(irq),
      .BUS_ERR_IRQ(berr));
   xfer_partner xfer_partner_inst (.clk(mclk), .src_req(req),
      .delay(delay), .tmo_cmd(tcmd), .elem_done(edone),
      .port_timeout(tmo));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // ==========================================
   // event counters
   always @(posedge mclk) begin
      rprev <= req;
      if (req === 1'b1 && rprev === 1'b0) rises++;
      if (irq === 1'b1) irqs++;
      if (berr === 1'b1) berrs++;
      if (edone === 1'b1 && req === 1'b1) dones++;
   end

   // ==========================================
   // tasks
   task automatic print_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_cnt(input int g, input int e);
      checks++;
      if (g != e) begin
         miscompares++;
         $display("Error at %0t: count %h expected %h", $time, g, e);
      end
   endtask
   // classic cycle held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
      int n;
      @(posedge mclk);
      {cyc, stb, we, adr} <= {2'b11, w, a};
      wdat <= {16'h0000, d};
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) begin
         miscompares++;
         print_verdict();
      end
      got = rdat;
      {cyc, stb, we} <= 3'b000;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      wb(1'b1, a, d);
      mdl[a] = (a == OFS_IRQ_EN) ? (d & IEN_WMASK) : d;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 16'h0000);
      chk_reg(got, e);
   endtask
   // bounded wait on the request (0) or the enable (1)
   task automatic wait_for(input int s, input logic l);
      int n;
      n = 0;
      while (((s == 0) ? req : act) !== l && n < 400) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 400) begin
         miscompares++;
         print_verdict();
      end
   endtask
   task automatic trig(input int c);
      @(posedge mclk);
      pins[c-1] <= 1'b1;
      repeat (2) @(posedge mclk);
      pins[c-1] <= 1'b0;
   endtask
   task automatic tpulse;
      @(posedge mclk);
      tcmd <= 1'b1;
      @(posedge mclk);
      tcmd <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask

   // ==========================================
   // main sequence
   initial begin
      {rst, cyc, stb, we, tcmd, rprev} = 6'b100000;
      {adr, wdat, pins} = '0;
      sel = 4'h3;
      delay = 4'h2;
      {miscompares, checks, rises, irqs, berrs, dones} = '0;
      void'($urandom(85));
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      rd(OFS_CONTROL, 32'h0);
      rd(OFS_IRQ_EN, 32'h3);
      rd(OFS_STATUS, 32'h0);
      rd(8'h40, 32'h0);
      rd(OFS_PARAMS, 32'h0);
      for (int i = 0; i < 4; i++) begin
         v = 16'($urandom);
         v[15:14] = i[1:0];
         v[8:7] = ~i[1:0];
         wr(OFS_PARAMS, v);
         rd(OFS_PARAMS, {16'h0, 16'(mdl[OFS_PARAMS])});
         chk_reg({31'h0, dbur}, {31'h0, v[15:14] == 2'b10});
         chk_reg({31'h0, sbur}, {31'h0, v[8:7] == 2'b10});
         chk_reg({16'h0, prm}, {16'h0, v});
      end
      // free run, two frames of four
      wr(OFS_IRQ_EN, 16'h003f);
      wr(OFS_ELEM_NUM, 16'h0004);
      wr(OFS_FRAME_NUM, 16'h0002);
      {rises, irqs, dones} = '0;
      wr(OFS_CONTROL, 16'h00a0);
      wait_for(1, 1'b1);
      wait_for(1, 1'b0);
      repeat (3) @(posedge mclk);
      chk_cnt(rises, 2);
      chk_cnt(dones, 8);
      chk_cnt(irqs, 5);
      rd(OFS_CONTROL, 32'h20);
      rd(OFS_STATUS, 32'h3c);
      rd(OFS_STATUS, 32'h0);
      // element sync on a random code, nothing enabled
      code = 1 + $urandom_range(19);
      wr(OFS_IRQ_EN, 16'h0000);
      wr(OFS_ELEM_NUM, 16'h0003);
      wr(OFS_FRAME_NUM, 16'h0001);
      {rises, irqs} = '0;
      wr(OFS_CONTROL, {11'h004, code[4:0]});
      repeat (20) @(posedge mclk);
      chk_cnt(rises, 0);
      for (int k = 0; k < 3; k++) begin
         trig(code);
         wait_for(0, 1'b1);
         wait_for(0, 1'b0);
      end
      wait_for(1, 1'b0);
      chk_cnt(rises, 3);
      chk_cnt(irqs, 0);
      rd(OFS_STATUS, 32'h0);
      // frame sync, slow far side, second trigger is dropped
      delay <= 4'h9;
      wr(OFS_IRQ_EN, 16'h0002);
      wr(OFS_ELEM_NUM, 16'h0004);
      irqs = 0;
      wr(OFS_CONTROL, {11'h005, code[4:0]});
      trig(code);
      wait_for(0, 1'b1);
      rd(OFS_STATUS, 32'h40);
      trig(code);
      wait_for(1, 1'b0);
      repeat (3) @(posedge mclk);
      chk_cnt(irqs, 1);
      rd(OFS_STATUS, 32'h02);
      // port timeouts, reserved enable bits read zero
      wr(OFS_IRQ_EN, 16'hffc1);
      rd(OFS_IRQ_EN, 32'(mdl[OFS_IRQ_EN]));
      berrs = 0;
      tpulse();
      chk_cnt(berrs, 1);
      rd(OFS_STATUS, 32'h01);
      wr(OFS_IRQ_EN, 16'h0000);
      tpulse();
      chk_cnt(berrs, 1);
      rd(OFS_STATUS, 32'h0);
      print_verdict();
   end
endmodule

// ---- verif/xfer_partner.sv ----
`timescale 1ns/1ps
// ==========================================
// far side: ports answering the channel
module xfer_partner (
   // clock
   input  wire logic       clk,
   // pacing and commands
   input  wire logic       src_req,
   input  wire logic [3:0] delay,
   input  wire logic       tmo_cmd,
   // answers
   output logic            elem_done,
   output logic            port_timeout
);
   logic [3:0] wait_reg;
   // counter restarts after each pulse, so with a nonzero delay no pulse lands as req falls
   always_ff @(posedge clk) begin
      elem_done    <= 1'b0;
      port_timeout <= tmo_cmd;
      if (!src_req) begin
         wait_reg <= 4'h0;
      end else if (wait_reg >= delay) begin
         elem_done <= 1'b1;
         wait_reg  <= 4'h0;
      end else begin
         wait_reg <= wait_reg + 4'h1;
      end
   end
endmodule
